// ==== rtl/phc_pkg.sv ====
// Package holding the register map, field layout and reset values of the port H pin configuration block
package phc_pkg;

  localparam int PHC_PINS = 5;
  localparam int PHC_ADDR_W = 12;
  localparam int PHC_DATA_W = 32;

  typedef logic [PHC_PINS-1:0] phc_pins_t;

  // Register byte offsets
  localparam logic [PHC_ADDR_W-1:0] PHC_OFS_ALT_SELECT_THREE = 12'h010;
  localparam logic [PHC_ADDR_W-1:0] PHC_OFS_ALT_SELECT_FOUR = 12'h014;
  localparam logic [PHC_ADDR_W-1:0] PHC_OFS_DRIVE_TYPE = 12'h028;
  localparam logic [PHC_ADDR_W-1:0] PHC_OFS_PULLUP_ENABLE = 12'h02C;
  localparam logic [PHC_ADDR_W-1:0] PHC_OFS_INPUT_ENABLE = 12'h038;

  // Implemented bits of each register
  localparam phc_pins_t PHC_ALT3_MASK = 5'h1C;
  localparam phc_pins_t PHC_ALT4_MASK = 5'h1C;
  localparam phc_pins_t PHC_DRIVE_MASK = 5'h1F;
  localparam phc_pins_t PHC_PULLUP_MASK = 5'h1F;
  localparam phc_pins_t PHC_INPUT_MASK = 5'h1F;

  // Field positions inside the alternate-select registers
  localparam int PHC_BIT_PIN4 = 4;
  localparam int PHC_BIT_PIN3 = 3;
  localparam int PHC_BIT_PIN2 = 2;

  // Values after reset
  localparam phc_pins_t PHC_RST_ALT3 = 5'h00;
  localparam phc_pins_t PHC_RST_ALT4 = 5'h00;
  localparam phc_pins_t PHC_RST_DRIVE = 5'h00;
  localparam phc_pins_t PHC_RST_PULLUP = 5'h00;
  localparam phc_pins_t PHC_RST_INPUT = 5'h00;
  localparam logic [PHC_DATA_W-1:0] PHC_RST_RDATA = 32'h0000_0000;

  // AHB transfer type and response
  localparam logic [1:0] PHC_HTRANS_NONSEQ = 2'b10;
  localparam logic PHC_HRESP_OKAY = 1'b0;

endpackage : phc_pkg

// ==== rtl/phc_pin_cell.sv ====
// Pad control cell for one port H pin: drive type, pull-up, input gating and function routing
`timescale 1ns/100ps
module phc_pin_cell
  import phc_pkg::*;
(
  input wire logic clk_sys,
  input wire logic sys_rst,
  input wire logic drive_open_drain,
  input wire logic pullup_on,
  input wire logic input_on,
  input wire logic fn_out_sel,
  input wire logic fn_in_sel,
  input wire logic fn_out,
  input wire logic port_out,
  input wire logic port_oe,
  input wire logic pad_in,
  output logic pad_out,
  output logic pad_oe,
  output logic pad_pullup_en,
  output logic pad_input_en,
  output logic port_in,
  output logic fn_in
);

  logic drv_val;
  logic drv_en;
  logic gated_in;
  logic pad_out_q;
  logic pad_oe_q;
  logic pad_pullup_en_q;
  logic pad_input_en_q;
  logic port_in_q;
  logic fn_in_q;

  // Function output wins over port data; a function input never drives the pin
  assign drv_val = fn_out_sel ? fn_out : port_out;
  assign drv_en = fn_out_sel | (port_oe & ~fn_in_sel);
  // Open drain drives only the low level; push-pull drives both
  assign gated_in = pad_in & input_on;

  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      pad_out_q <= 1'b0;
      pad_oe_q <= 1'b0;
      pad_pullup_en_q <= 1'b0;
      pad_input_en_q <= 1'b0;
      port_in_q <= 1'b0;
      fn_in_q <= 1'b0;
    end else begin
      pad_out_q <= drv_val & ~drive_open_drain;
      pad_oe_q <= drv_en & (~drive_open_drain | ~drv_val);
      pad_pullup_en_q <= pullup_on;
      pad_input_en_q <= input_on;
      port_in_q <= gated_in;
      fn_in_q <= gated_in & fn_in_sel;
    end
  end

  assign pad_out = pad_out_q;
  assign pad_oe = pad_oe_q;
  assign pad_pullup_en = pad_pullup_en_q;
  assign pad_input_en = pad_input_en_q;
  assign port_in = port_in_q;
  assign fn_in = fn_in_q;

endmodule : phc_pin_cell

// ==== rtl/phc_port_h_config.sv ====
// Port H pin configuration block with its register file on an AHB-Lite slave
//
// Our own choices: the AHB-Lite interface to the registers and the register addresses.
`timescale 1ns/100ps
module phc_port_h_config
  import phc_pkg::*;
#(
  parameter int PINS = PHC_PINS
)
(
  input wire logic clk_sys,
  input wire logic sys_rst,
  input wire logic hsel,
  input wire logic [PHC_ADDR_W-1:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic hready,
  input wire logic [PHC_DATA_W-1:0] hwdata,
  output logic [PHC_DATA_W-1:0] hrdata,
  output logic hreadyout,
  output logic hresp,
  input wire logic [PINS-1:0] port_data_out,
  input wire logic [PINS-1:0] port_out_enable,
  output logic [PINS-1:0] port_data_in,
  input wire logic [PINS-1:0] pad_in,
  output logic [PINS-1:0] pad_out,
  output logic [PINS-1:0] pad_oe,
  output logic [PINS-1:0] pad_pullup_en,
  output logic [PINS-1:0] pad_input_en,
  input wire logic timer_five_output,
  input wire logic timer_four_output,
  input wire logic serial2_terminal_ready,
  output logic external_interrupt_eight,
  output logic serial2_set_ready,
  output logic serial2_carrier_detect
);

  phc_pins_t alt3_q;
  phc_pins_t alt3_d;
  phc_pins_t alt4_q;
  phc_pins_t alt4_d;
  phc_pins_t drive_q;
  phc_pins_t drive_d;
  phc_pins_t pullup_q;
  phc_pins_t pullup_d;
  phc_pins_t input_q;
  phc_pins_t input_d;
  logic wr_pend_q;
  logic [PHC_ADDR_W-1:0] wr_addr_q;
  logic [PHC_DATA_W-1:0] hrdata_q;
  logic [PHC_DATA_W-1:0] hrdata_d;

  // Address phase qualification
  wire xfer_ok = hsel & (htrans == PHC_HTRANS_NONSEQ) & hready;
  wire rd_req = xfer_ok & ~hwrite;
  wire wr_req = xfer_ok & hwrite;

  // Write decode in the data phase
  wire wr_alt3 = wr_pend_q & (wr_addr_q == PHC_OFS_ALT_SELECT_THREE);
  wire wr_alt4 = wr_pend_q & (wr_addr_q == PHC_OFS_ALT_SELECT_FOUR);
  wire wr_drive = wr_pend_q & (wr_addr_q == PHC_OFS_DRIVE_TYPE);
  wire wr_pullup = wr_pend_q & (wr_addr_q == PHC_OFS_PULLUP_ENABLE);
  wire wr_input = wr_pend_q & (wr_addr_q == PHC_OFS_INPUT_ENABLE);
  wire phc_pins_t wdata_pins = hwdata[PINS-1:0];

  // Next register values; bits outside each mask ignore writes
  assign alt3_d = wr_alt3 ? (wdata_pins & PHC_ALT3_MASK) : alt3_q;
  assign alt4_d = wr_alt4 ? (wdata_pins & PHC_ALT4_MASK) : alt4_q;
  assign drive_d = wr_drive ? (wdata_pins & PHC_DRIVE_MASK) : drive_q;
  assign pullup_d = wr_pullup ? (wdata_pins & PHC_PULLUP_MASK) : pullup_q;
  assign input_d = wr_input ? (wdata_pins & PHC_INPUT_MASK) : input_q;

  // Read decode; a read right after a write sees the written value
  wire rd_alt3 = haddr == PHC_OFS_ALT_SELECT_THREE;
  wire rd_alt4 = haddr == PHC_OFS_ALT_SELECT_FOUR;
  wire rd_drive = haddr == PHC_OFS_DRIVE_TYPE;
  wire rd_pullup = haddr == PHC_OFS_PULLUP_ENABLE;
  wire rd_input = haddr == PHC_OFS_INPUT_ENABLE;
  wire phc_pins_t rd_pins = rd_alt3 ? alt3_d :
                            rd_alt4 ? alt4_d :
                            rd_drive ? drive_d :
                            rd_pullup ? pullup_d :
                            rd_input ? input_d : PHC_RST_ALT3;
  // Upper bits and unmapped offsets read as zero
  assign hrdata_d = rd_req ? {{(PHC_DATA_W-PINS){1'b0}}, rd_pins} : PHC_RST_RDATA;

  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      alt3_q <= PHC_RST_ALT3;
      alt4_q <= PHC_RST_ALT4;
      drive_q <= PHC_RST_DRIVE;
      pullup_q <= PHC_RST_PULLUP;
      input_q <= PHC_RST_INPUT;
    end else begin
      alt3_q <= alt3_d;
      alt4_q <= alt4_d;
      drive_q <= drive_d;
      pullup_q <= pullup_d;
      input_q <= input_d;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      wr_pend_q <= 1'b0;
      wr_addr_q <= '0;
      hrdata_q <= PHC_RST_RDATA;
    end else begin
      wr_pend_q <= wr_req;
      wr_addr_q <= haddr;
      hrdata_q <= hrdata_d;
    end
  end

  // Zero wait states, always OKAY
  assign hrdata = hrdata_q;
  assign hreadyout = 1'b1;
  assign hresp = PHC_HRESP_OKAY;

  // Per-pin function routing; select three wins when both are set
  phc_pins_t alt_out_sel;
  phc_pins_t alt_in_sel;
  phc_pins_t alt_out_val;
  phc_pins_t alt_in_val;

  assign alt_in_sel[PHC_BIT_PIN4] = alt3_q[PHC_BIT_PIN4];
  assign alt_out_sel[PHC_BIT_PIN4] = alt4_q[PHC_BIT_PIN4] & ~alt3_q[PHC_BIT_PIN4];
  assign alt_out_val[PHC_BIT_PIN4] = serial2_terminal_ready;
  assign alt_out_sel[PHC_BIT_PIN3] = alt3_q[PHC_BIT_PIN3];
  assign alt_in_sel[PHC_BIT_PIN3] = alt4_q[PHC_BIT_PIN3] & ~alt3_q[PHC_BIT_PIN3];
  assign alt_out_val[PHC_BIT_PIN3] = timer_five_output;
  assign alt_out_sel[PHC_BIT_PIN2] = alt3_q[PHC_BIT_PIN2];
  assign alt_in_sel[PHC_BIT_PIN2] = alt4_q[PHC_BIT_PIN2] & ~alt3_q[PHC_BIT_PIN2];
  assign alt_out_val[PHC_BIT_PIN2] = timer_four_output;
  assign alt_out_sel[1:0] = 2'b00;
  assign alt_in_sel[1:0] = 2'b00;
  assign alt_out_val[1:0] = 2'b00;

  generate
    for (genvar i = 0; i < PINS; i++) begin : g_pin
      phc_pin_cell u_cell (
        .clk_sys(clk_sys),
        .sys_rst(sys_rst),
        .drive_open_drain(drive_q[i]),
        .pullup_on(pullup_q[i]),
        .input_on(input_q[i]),
        .fn_out_sel(alt_out_sel[i]),
        .fn_in_sel(alt_in_sel[i]),
        .fn_out(alt_out_val[i]),
        .port_out(port_data_out[i]),
        .port_oe(port_out_enable[i]),
        .pad_in(pad_in[i]),
        .pad_out(pad_out[i]),
        .pad_oe(pad_oe[i]),
        .pad_pullup_en(pad_pullup_en[i]),
        .pad_input_en(pad_input_en[i]),
        .port_in(port_data_in[i]),
        .fn_in(alt_in_val[i])
      );
    end
  endgenerate

  // Function inputs to the interrupt controller and serial channel 2
  assign external_interrupt_eight = alt_in_val[PHC_BIT_PIN4];
  assign serial2_set_ready = alt_in_val[PHC_BIT_PIN3];
  assign serial2_carrier_detect = alt_in_val[PHC_BIT_PIN2];

  // Checks
  default clocking cb @(posedge clk_sys);
  endclocking
  default disable iff (sys_rst);

  a_external_interrupt_eight_route: assert property (
    $past(alt3_q[4] & input_q[4]) |-> external_interrupt_eight == $past(pad_in[4]))
    else $error("interrupt eight does not follow pin 4");

  a_timer5_drive: assert property (
    $past(alt3_q[3] & ~drive_q[3]) |-> pad_oe[3] && pad_out[3] == $past(timer_five_output))
    else $error("pin 3 does not carry timer five output");

  a_timer4_drive: assert property (
    $past(alt3_q[2] & ~drive_q[2]) |-> pad_oe[2] && pad_out[2] == $past(timer_four_output))
    else $error("pin 2 does not carry timer four output");

  a_dtr_drive: assert property (
    $past(alt4_q[4] & ~alt3_q[4] & ~drive_q[4]) |-> pad_oe[4] && pad_out[4] == $past(serial2_terminal_ready))
    else $error("pin 4 does not carry terminal ready");

  a_dsr_dcd_in: assert property (
    $past(alt4_q[3] & ~alt3_q[3] & input_q[3]) ##0 $past(alt4_q[2] & ~alt3_q[2] & input_q[2])
    |-> serial2_set_ready == $past(pad_in[3]) && serial2_carrier_detect == $past(pad_in[2]))
    else $error("set ready or carrier detect does not follow its pin");

  a_plain_port: assert property (
    $past(~alt3_q[3] & ~alt4_q[3] & ~drive_q[3]) |->
    pad_out[3] == $past(port_data_out[3]) && pad_oe[3] == $past(port_out_enable[3]))
    else $error("pin 3 in port use does not follow port data");

  a_open_drain: assert property (
    (pad_out & $past(drive_q)) == 5'h00 &&
    (pad_oe & $past(drive_q & port_data_out & ~alt3_q & ~alt4_q)) == 5'h00 &&
    ($past(drive_q & port_out_enable & ~port_data_out & ~alt3_q & ~alt4_q) & ~pad_oe) == 5'h00)
    else $error("open-drain pin drives high or fails to pull low");

  a_pullup_follow: assert property (
    ##1 pad_pullup_en == $past(pullup_q))
    else $error("pull-up enable does not follow its register");

  a_input_gate: assert property (
    ##1 (port_data_in & ~$past(input_q)) == 5'h00 && pad_input_en == $past(input_q))
    else $error("disabled input reaches the port");

  a_reserved_zero: assert property (
    hrdata[PHC_DATA_W-1:PINS] == '0 && (alt3_q & ~PHC_ALT3_MASK) == 5'h00 && (alt4_q & ~PHC_ALT4_MASK) == 5'h00)
    else $error("unused bit reads or holds one");

  a_write_lands: assert property (
    wr_req && haddr == PHC_OFS_DRIVE_TYPE ##1 1'b1 |=> drive_q == $past(hwdata[PINS-1:0]))
    else $error("drive-type write did not land");

  a_read_back: assert property (
    rd_req && haddr == PHC_OFS_PULLUP_ENABLE && !wr_pend_q |=> hrdata == {27'h000_0000, $past(pullup_q)})
    else $error("pull-up register read back wrong");

  a_unmapped_zero: assert property (
    rd_req && !(rd_alt3 | rd_alt4 | rd_drive | rd_pullup | rd_input) |=> hrdata == PHC_RST_RDATA)
    else $error("unmapped read not zero");

  a_reset_clear: assert property (@(posedge clk_sys) disable iff (1'b0)
    sys_rst |=> alt3_q == 5'h00 && alt4_q == 5'h00 && drive_q == 5'h00 && pullup_q == 5'h00 && input_q == 5'h00)
    else $error("field not cleared by reset");

  // Inward routes leave the pin undriven and idle lines low; push-pull pins 0 and 1 follow port data
  a_alt3_wins: assert property (
    $past(alt3_q[4]) |-> !pad_oe[4])
    else $error("pin 4 driven while routed to interrupt eight");

  a_dsr_no_drive: assert property (
    $past(alt4_q[3] & ~alt3_q[3]) |-> !pad_oe[3])
    else $error("pin 3 driven while routed to set ready");

  a_dcd_no_drive: assert property (
    $past(alt4_q[2] & ~alt3_q[2]) |-> !pad_oe[2])
    else $error("pin 2 driven while routed to carrier detect");

  a_external_interrupt_eight_idle: assert property (
    !$past(alt3_q[4]) |-> !external_interrupt_eight)
    else $error("interrupt eight active in port use");

  a_dsr_idle: assert property (
    !$past(alt4_q[3] & ~alt3_q[3]) |-> !serial2_set_ready)
    else $error("set ready active without its route");

  a_dcd_idle: assert property (
    !$past(alt4_q[2] & ~alt3_q[2]) |-> !serial2_carrier_detect)
    else $error("carrier detect active without its route");

  a_low_pins_port: assert property (
    $past(!sys_rst && drive_q[1:0] == 2'b00) |->
    pad_out[1:0] == $past(port_data_out[1:0]) && pad_oe[1:0] == $past(port_out_enable[1:0]))
    else $error("push-pull pin 0 or 1 does not follow port data");

  // Register file and bus checks
  a_bus_okay: assert property (
    hreadyout && hresp == PHC_HRESP_OKAY)
    else $error("slave inserted a wait or an error response");

  a_idle_read_zero: assert property (
    !rd_req |=> hrdata == PHC_RST_RDATA)
    else $error("read data stands beyond its data phase");

  a_reg_hold: assert property (
    !wr_pend_q |=> $stable(alt3_q) && $stable(alt4_q) && $stable(drive_q) &&
    $stable(pullup_q) && $stable(input_q))
    else $error("register changed without a write");

  a_alt3_mask: assert property (
    wr_pend_q && wr_addr_q == PHC_OFS_ALT_SELECT_THREE |=> alt3_q == ($past(hwdata[PINS-1:0]) & PHC_ALT3_MASK))
    else $error("select three write wrong");

  a_alt4_mask: assert property (
    wr_pend_q && wr_addr_q == PHC_OFS_ALT_SELECT_FOUR |=> alt4_q == ($past(hwdata[PINS-1:0]) & PHC_ALT4_MASK))
    else $error("select four write wrong");

  a_pullup_lands: assert property (
    wr_pend_q && wr_addr_q == PHC_OFS_PULLUP_ENABLE |=> pullup_q == ($past(hwdata[PINS-1:0]) & PHC_PULLUP_MASK))
    else $error("pull-up write did not land");

  a_input_lands: assert property (
    wr_pend_q && wr_addr_q == PHC_OFS_INPUT_ENABLE |=> input_q == ($past(hwdata[PINS-1:0]) & PHC_INPUT_MASK))
    else $error("input-enable write did not land");

  c_external_interrupt_eight_used: cover property (alt3_q[4] && input_q[4] && external_interrupt_eight);
  c_open_drain_low: cover property (drive_q[1] && pad_oe[1] && !pad_out[1]);
  c_serial_route: cover property (alt4_q[4] && !alt3_q[4] && pad_oe[4]);
  c_write_then_read: cover property (wr_req ##2 rd_req);

endmodule : phc_port_h_config

// ==== testbench/phc_pin_model.sv ====
// Model of the board side of the port H pins: resolves each pad to one level
`timescale 1ns/100ps
module phc_pin_model
  import phc_pkg::*;
(
  input wire logic clk_sys,
  input wire logic [PHC_PINS-1:0] pad_out,
  input wire logic [PHC_PINS-1:0] pad_oe,
  input wire logic [PHC_PINS-1:0] pad_pullup_en,
  input wire logic [PHC_PINS-1:0] ext_en,
  input wire logic [PHC_PINS-1:0] ext_val,
  output logic [PHC_PINS-1:0] pad_in
);
  logic [PHC_PINS-1:0] last_q = '0;

  // A floating pin shows the inverse of its last level each cycle
  always_comb begin
    for (int i = 0; i < PHC_PINS; i++) begin
      if (pad_oe[i]) begin
        pad_in[i] = pad_out[i];
      end else if (ext_en[i]) begin
        pad_in[i] = ext_val[i];
      end else if (pad_pullup_en[i]) begin
        pad_in[i] = 1'b1;
      end else begin
        pad_in[i] = ~last_q[i];
      end
    end
  end

  always @(posedge clk_sys) begin
    last_q <= pad_in;
  end
endmodule : phc_pin_model

// ==== testbench/phc_port_h_config_test.sv ====
// Self-checking testbench for the port H pin configuration block
`timescale 1ns/100ps
module phc_port_h_config_test
  import phc_pkg::*;
;
  logic clk_sys, sys_rst, hsel, hwrite, hready, hreadyout, hresp;
  logic [PHC_ADDR_W-1:0] haddr;
  logic [1:0] htrans;
  logic [2:0] hsize;
  logic [31:0] hwdata, hrdata, d;
  logic [4:0] port_data_out, port_out_enable, port_data_in, pad_in, pad_out, pad_oe;
  logic [4:0] pad_pullup_en, pad_input_en, ext_en, ext_val;
  logic timer_five_output, timer_four_output, serial2_terminal_ready;
  logic external_interrupt_eight, serial2_set_ready, serial2_carrier_detect;
  int n_fail, cmp_count, cyc;
  logic [11:0] ofs [5] = '{PHC_OFS_ALT_SELECT_THREE, PHC_OFS_ALT_SELECT_FOUR, PHC_OFS_DRIVE_TYPE,
    PHC_OFS_PULLUP_ENABLE, PHC_OFS_INPUT_ENABLE};
  logic [4:0] msk [5] = '{PHC_ALT3_MASK, PHC_ALT4_MASK, PHC_DRIVE_MASK, PHC_PULLUP_MASK, PHC_INPUT_MASK};

  assign hready = hreadyout;
  phc_port_h_config dut_u (
    .clk_sys(clk_sys), .sys_rst(sys_rst), .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
    .hsize(hsize), .hready(hready), .hwdata(hwdata), .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp),
    .port_data_out(port_data_out), .port_out_enable(port_out_enable), .port_data_in(port_data_in),
    .pad_in(pad_in), .pad_out(pad_out), .pad_oe(pad_oe), .pad_pullup_en(pad_pullup_en),
    .pad_input_en(pad_input_en), .timer_five_output(timer_five_output), .timer_four_output(timer_four_output),
    .serial2_terminal_ready(serial2_terminal_ready), .external_interrupt_eight(external_interrupt_eight),
    .serial2_set_ready(serial2_set_ready), .serial2_carrier_detect(serial2_carrier_detect)
  );
  phc_pin_model pm_u (
    .clk_sys(clk_sys), .pad_out(pad_out), .pad_oe(pad_oe), .pad_pullup_en(pad_pullup_en),
    .ext_en(ext_en), .ext_val(ext_val), .pad_in(pad_in)
  );

  initial begin
    clk_sys = 0;
    forever #5 clk_sys = ~clk_sys;
  end

  task end_of_test;
    $display("Compares %0d mismatches %0d", cmp_count, n_fail);
    if (n_fail == 0 && cmp_count > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask : end_of_test

  always @(posedge clk_sys) begin
    cyc <= cyc + 1;
    if (cyc == 5000) begin
      n_fail++;
      end_of_test();
    end
  end

  task chk(input logic [31:0] seen, input logic [31:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      n_fail++;
      $display("Error at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask : chk

  // One single transfer, called just after a rising edge; read data taken at the closing edge
  task bus(input logic wr, input logic [11:0] a, input logic [31:0] wd);
    hsel <= 1'b1;
    htrans <= PHC_HTRANS_NONSEQ;
    haddr <= a;
    hwrite <= wr;
    do @(posedge clk_sys); while (hready !== 1'b1);
    hsel <= 1'b0;
    htrans <= 2'b00;
    hwdata <= wd;
    do @(posedge clk_sys); while (hready !== 1'b1);
    d = hrdata;
    chk(32'(hresp), 32'(PHC_HRESP_OKAY));
  endtask : bus

  // Outputs are read just after a rising edge, as settled before it
  task settle;
    repeat (3) @(posedge clk_sys);
  endtask : settle

  initial begin
    {sys_rst, cyc, n_fail, cmp_count} = '0;
    sys_rst = 1;
    {hsel, hwrite, haddr, htrans, hwdata, port_data_out, port_out_enable} = '0;
    {ext_en, ext_val, timer_five_output, timer_four_output, serial2_terminal_ready} = '0;
    hsize = 3'b010;
    repeat (3) @(posedge clk_sys);
    sys_rst <= 0;
    for (int i = 0; i < 5; i++) begin
      bus(0, ofs[i], 0);
      chk(d, 0);
      bus(1, ofs[i], 32'hFFFF_FFFF);
      bus(0, ofs[i], 0);
      chk(d, 32'(msk[i]));
      bus(1, ofs[i], 0);
    end
    bus(1, 12'h018, 32'hFFFF_FFFF);
    bus(0, 12'h018, 0);
    chk(d, 0);
    $display("Register test done");
    port_out_enable <= 5'h1F;
    port_data_out <= 5'h15;
    settle();
    chk(32'({pad_out, pad_oe}), 32'h2BF);
    bus(1, PHC_OFS_DRIVE_TYPE, 32'h0000_0003);
    settle();
    chk(32'({pad_out, pad_oe}), 32'h29E);
    bus(1, PHC_OFS_PULLUP_ENABLE, 32'h0000_000B);
    settle();
    chk(32'(pad_pullup_en), 32'h0B);
    chk(32'(pad_in[1:0]), 32'h1);
    port_out_enable <= 0;
    ext_en <= 5'h1F;
    ext_val <= 5'h16;
    bus(1, PHC_OFS_INPUT_ENABLE, 32'h0000_000D);
    settle();
    chk(32'({pad_input_en, port_data_in}), 32'h1A4);
    $display("Drive and input test done");
    bus(1, PHC_OFS_DRIVE_TYPE, 0);
    bus(1, PHC_OFS_INPUT_ENABLE, 32'h0000_001F);
    ext_val <= 5'h10;
    bus(1, PHC_OFS_ALT_SELECT_THREE, 32'h0000_001C);
    for (int t = 0; t < 4; t++) begin
      timer_five_output <= t[1];
      timer_four_output <= t[0];
      settle();
      chk(32'({external_interrupt_eight, pad_oe[3:2], pad_out[3:2]}), 32'(t) | 32'h1C);
    end
    ext_val <= 5'h00;
    settle();
    chk(32'(external_interrupt_eight), 0);
    bus(1, PHC_OFS_ALT_SELECT_THREE, 0);
    ext_val <= 5'h0C;
    serial2_terminal_ready <= 1;
    bus(1, PHC_OFS_ALT_SELECT_FOUR, 32'h0000_001C);
    settle();
    chk(32'({pad_oe[4], pad_out[4], serial2_set_ready, serial2_carrier_detect}), 32'hF);
    ext_val <= 5'h04;
    serial2_terminal_ready <= 0;
    settle();
    chk(32'({pad_oe[4], pad_out[4], serial2_set_ready, serial2_carrier_detect}), 32'h9);
    bus(1, PHC_OFS_INPUT_ENABLE, 0);
    settle();
    chk(32'({serial2_set_ready, serial2_carrier_detect, external_interrupt_eight}), 0);
    $display("Function routing test done");
    sys_rst <= 1;
    repeat (2) @(posedge clk_sys);
    sys_rst <= 0;
    bus(0, PHC_OFS_ALT_SELECT_FOUR, 0);
    chk(d, 0);
    chk(32'(pad_oe), 0);
    bus(0, PHC_OFS_PULLUP_ENABLE, 0);
    chk(d, 0);
    $display("Second reset test done");
    end_of_test();
  end
endmodule : phc_port_h_config_test
